// >>> rtl/prioritized_interrupt_controller.sv
// Interrupt controller: source state, arbitration, nesting and APB registers
module prioritized_interrupt_controller
  import irq_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [irq_ctrl_pkg::NUM_SRC-1:0] irq_src,
  input wire logic special_high_interrupt,
  output logic irq_req,
  output logic [6:0] irq_vector,
  input wire logic irq_ack,
  input wire logic irq_return,
  output logic soft_reset_req
);
  import irq_ctrl_pkg::*;

  logic [NUM_SRC-1:0] enable_q;
  logic [NUM_SRC-1:0] mode_pulse_q;
  logic [7:0] pri_sel_q [NUM_SRC];
  logic [31:0] sys_sel_q;
  logic [NUM_ALL-1:0] pend_q;
  logic [NUM_ALL-1:0] active_q;
  logic [NUM_ALL-1:0] pulse_seen_q;
  logic [NUM_ALL-1:0] line_prev_q;
  logic [6:0] cur_vec_q;
  logic [DEPTH_W-1:0] depth_q;
  logic [5:0] stack_q [NUM_ALL];
  logic signed [PRI_W-1:0] pri_stack_q [NUM_ALL];
  logic signed [PRI_W-1:0] cur_pri_q;
  logic [5:0] cur_idx_q;
  logic req_q;
  logic [5:0] req_idx_q;
  logic [NUM_ALL-1:0] line;
  logic [NUM_ALL-1:0] eligible;
  logic signed [PRI_W-1:0] pri [NUM_ALL];
  logic signed [PRI_W-1:0] best_pri;
  logic [5:0] best_idx;
  logic best_valid;
  logic wr_access;
  logic rd_access;
  logic addr_ok;
  logic [NUM_ALL-1:0] pend_set_sw;
  logic [NUM_ALL-1:0] pend_clr_sw;
  logic [5:0] ret_idx;
  logic [31:0] rdata_d;
  logic [NUM_ALL-1:0] rise_vec;
  logic [NUM_ALL-1:0] pulse_kind;
  logic [NUM_ALL-1:0] hw_set;
  logic [NUM_ALL-1:0] take_hit;
  logic [NUM_ALL-1:0] ret_hit;
  logic [6:0] best_vec;

  // Special line and trap share the per-source machinery; trap has no line
  assign line = {1'b0, special_high_interrupt, irq_src};

  always_comb
  begin
    for (int i = 0; i < NUM_SRC; i++)
    begin
      pri[i] = PRI_W'(i) + $signed({2'b00, pri_sel_q[i][SEL_FIELD_LSB +: 2], 6'h00});
    end
    pri[IDX_SPECIAL] = PRI_SPECIAL_BASE
      + $signed({2'b00, sys_sel_q[SYS_SPECIAL_FIELD_LSB +: 2], 6'h00});
    pri[IDX_SOFT] = PRI_SOFT_BASE
      + $signed({2'b00, sys_sel_q[SYS_SOFT_FIELD_LSB +: 2], 6'h00});
  end

  // Normal sources gated by their enable; system sources always allowed
  assign eligible = pend_q & ~active_q & {2'b11, enable_q};

  always_comb
  begin
    best_pri = cur_pri_q;
    best_idx = 6'h00;
    best_valid = 1'b0;
    for (int i = 0; i < NUM_ALL; i++)
    begin
      if (eligible[i] && (pri[i] < best_pri))
      begin
        best_pri = pri[i];
        best_idx = 6'(i);
        best_valid = 1'b1;
      end
    end
  end

  assign wr_access = psel && penable && pwrite;
  assign rd_access = psel && penable && !pwrite;

  // Holes and misaligned addresses answer with an error; a misaligned address inside the select range still writes that select word
  always_comb
  begin
    case (paddr)
      OFF_CTRL_STATUS, OFF_ENABLE, OFF_PEND_SET, OFF_PEND_CLEAR, OFF_SYS_PRI_SEL, OFF_SRC_MODE:
        addr_ok = 1'b1;
      default:
        addr_ok = (paddr[1:0] == 2'b00) && (paddr >= OFF_PRI_SEL_FIRST)
          && (paddr <= OFF_PRI_SEL_LAST);
    endcase
  end

  always_comb
  begin
    case (best_idx)
      6'(IDX_SPECIAL): best_vec = VEC_SPECIAL;
      6'(IDX_SOFT): best_vec = VEC_SOFT;
      default: best_vec = VEC_FIRST_SRC + 7'(best_idx);
    endcase
  end

  always_comb
  begin
    pend_set_sw = '0;
    pend_clr_sw = '0;
    if (wr_access && pstrb == 4'hF)
    begin
      if (paddr == OFF_PEND_SET)
        pend_set_sw[NUM_SRC-1:0] = pwdata;
      if (paddr == OFF_PEND_CLEAR)
        pend_clr_sw[NUM_SRC-1:0] = pwdata;
      if (paddr == OFF_CTRL_STATUS)
      begin
        pend_set_sw[IDX_SOFT] = pwdata[CS_TRAP_SET_BIT];
        pend_clr_sw[IDX_SOFT] = pwdata[CS_TRAP_CLEAR_BIT];
      end
    end
  end

  assign ret_idx = cur_idx_q;

  // Special line is always edge-driven; trap has no line at all
  assign pulse_kind = {1'b0, 1'b1, mode_pulse_q};
  assign rise_vec = line & ~line_prev_q;

  always_comb
  begin
    for (int i = 0; i < NUM_ALL; i++)
    begin
      take_hit[i] = irq_ack && req_q && (req_idx_q == 6'(i));
      ret_hit[i] = irq_return && (depth_q != '0) && (ret_idx == 6'(i));
      hw_set[i] = (rise_vec[i] && !pend_q[i])
        || (line[i] && !pulse_kind[i] && !active_q[i]);
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      line_prev_q <= '0;
    else
      line_prev_q <= line;
  end

  // Hardware set wins over software clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (srst)
      pend_q <= '0;
    else
    begin
      for (int i = 0; i < NUM_ALL; i++)
      begin
        if (take_hit[i])
          pend_q[i] <= hw_set[i] && pulse_kind[i];
        else if (ret_hit[i] && pulse_kind[i])
          pend_q[i] <= pend_q[i] || pulse_seen_q[i] || rise_vec[i];
        else if (ret_hit[i])
          pend_q[i] <= pend_q[i] || line[i];
        else if (hw_set[i] || pend_set_sw[i])
          pend_q[i] <= 1'b1;
        else if (pend_clr_sw[i])
          pend_q[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      active_q <= '0;
    else
    begin
      for (int i = 0; i < NUM_ALL; i++)
      begin
        if (take_hit[i])
          active_q[i] <= 1'b1;
        else if (ret_hit[i])
          active_q[i] <= 1'b0;
      end
    end
  end

  // A pulse during service is remembered so the return can re-pend it
  always_ff @(posedge clk)
  begin
    if (srst)
      pulse_seen_q <= '0;
    else
    begin
      for (int i = 0; i < NUM_ALL; i++)
      begin
        if (take_hit[i] || ret_hit[i])
          pulse_seen_q[i] <= 1'b0;
        else if (active_q[i] && pulse_kind[i] && rise_vec[i])
          pulse_seen_q[i] <= 1'b1;
      end
    end
  end

  // Request toward the core; re-evaluated every cycle until taken
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      req_q <= 1'b0;
      req_idx_q <= 6'h00;
      irq_vector <= VEC_NONE;
    end
    else if (irq_ack && req_q)
    begin
      req_q <= 1'b0;
    end
    else
    begin
      req_q <= best_valid;
      req_idx_q <= best_idx;
      irq_vector <= best_vec;
    end
  end

  assign irq_req = req_q;

  // Nesting stack of interrupted levels; one slot per source, so it never overflows
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < NUM_ALL; i++)
      begin
        stack_q[i] <= 6'h00;
        pri_stack_q[i] <= PRI_IDLE;
      end
    end
    else if (irq_ack && req_q)
    begin
      stack_q[depth_q] <= cur_idx_q;
      pri_stack_q[depth_q] <= cur_pri_q;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      depth_q <= '0;
    else if (irq_ack && req_q)
      depth_q <= depth_q + 1'b1;
    else if (irq_return && depth_q != '0)
      depth_q <= depth_q - 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cur_pri_q <= PRI_IDLE;
      cur_idx_q <= 6'h00;
      cur_vec_q <= VEC_NONE;
    end
    else if (irq_ack && req_q)
    begin
      cur_idx_q <= req_idx_q;
      cur_pri_q <= pri[req_idx_q];
      cur_vec_q <= irq_vector;
    end
    else if (irq_return && depth_q != '0)
    begin
      cur_idx_q <= stack_q[depth_q - 1'b1];
      cur_pri_q <= pri_stack_q[depth_q - 1'b1];
      if (depth_q == 6'd1)
        cur_vec_q <= VEC_NONE;
      else if (stack_q[depth_q - 1'b1] == 6'(IDX_SPECIAL))
        cur_vec_q <= VEC_SPECIAL;
      else if (stack_q[depth_q - 1'b1] == 6'(IDX_SOFT))
        cur_vec_q <= VEC_SOFT;
      else
        cur_vec_q <= VEC_FIRST_SRC + 7'(stack_q[depth_q - 1'b1]);
    end
  end

  // Word-only registers ignore partial strobes rather than merge lanes
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      enable_q <= RESET_ENABLE;
      mode_pulse_q <= RESET_MODE;
    end
    else if (wr_access && pstrb == 4'hF)
    begin
      if (paddr == OFF_ENABLE)
        enable_q <= pwdata;
      if (paddr == OFF_SRC_MODE)
        mode_pulse_q <= pwdata;
    end
  end

  // Priority selects take byte lanes, one select per lane
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sys_sel_q <= 32'h0000_0000;
      for (int i = 0; i < NUM_SRC; i++)
        pri_sel_q[i] <= RESET_PRI_SEL;
    end
    else if (wr_access)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (pstrb[b] && paddr == OFF_SYS_PRI_SEL)
          sys_sel_q[8*b +: 8] <= pwdata[8*b +: 8];
        if (pstrb[b] && paddr >= OFF_PRI_SEL_FIRST && paddr <= OFF_PRI_SEL_LAST)
          pri_sel_q[{paddr[4:2], 2'(b)}] <= pwdata[8*b +: 8];
      end
    end
  end

  always_comb
  begin
    rdata_d = 32'h0000_0000;
    case (paddr)
      OFF_CTRL_STATUS:
      begin
        rdata_d[CS_TRAP_SET_BIT] = pend_q[IDX_SOFT];
        rdata_d[CS_TRAP_CLEAR_BIT] = pend_q[IDX_SOFT];
        rdata_d[CS_VEC_LSB +: 7] = cur_vec_q;
      end
      OFF_ENABLE: rdata_d = enable_q;
      OFF_PEND_SET: rdata_d = pend_q[NUM_SRC-1:0];
      OFF_PEND_CLEAR: rdata_d = pend_q[NUM_SRC-1:0];
      OFF_SYS_PRI_SEL: rdata_d = sys_sel_q;
      OFF_SRC_MODE: rdata_d = mode_pulse_q;
      default:
      begin
        if (paddr >= OFF_PRI_SEL_FIRST && paddr <= OFF_PRI_SEL_LAST)
          rdata_d = {pri_sel_q[{paddr[4:2], 2'd3}], pri_sel_q[{paddr[4:2], 2'd2}],
                     pri_sel_q[{paddr[4:2], 2'd1}], pri_sel_q[{paddr[4:2], 2'd0}]};
      end
    endcase
  end

  // Zero-wait slave: answer registered during setup, shown in the access cycle
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
    end
  end

  // Read data is zero outside a read so stale values never leak
  always_ff @(posedge clk)
  begin
    if (srst)
      prdata <= 32'h0000_0000;
    else
      prdata <= (psel && !penable && !pwrite && addr_ok) ? rdata_d : 32'h0000_0000;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      soft_reset_req <= 1'b0;
    else
      soft_reset_req <= wr_access && paddr == OFF_CTRL_STATUS && pstrb[3]
        && pwdata[CS_SOFT_RESET_BIT];
  end

  logic unused_rd;
  assign unused_rd = rd_access;
endmodule // prioritized_interrupt_controller

// >>> rtl/irq_ctrl_pkg.sv
// Constants and register map of the prioritized interrupt controller
// How it works
// - Thirty-two byte-wide priority select registers, one per normal source.
// - Source n defaults to priority n; a lower value always wins.
// - Effective priority adds 64 times select bits 7:6 to the default.
// - Special exception defaults to -2, raised by 64 times its system field.
// - Software trap defaults to -1, raised by 64 times its own field.
// - Sources may be level-sensitive or pulse, chosen per source.
// - Active request on a level source while not active makes the interrupt pending.
// - A rising edge on the request also makes it pending.
// - Entering the service routine turns pending into active.
// - Level source on return: pending if line still high, else inactive.
// - Pulse source watched while active; a pulse then leaves it pending.
// - Writing one to a pending clear bit clears that pending flag.
// - A lone pending interrupt is dispatched to the core at once.
// - Simultaneous requests: best priority first, the other after return.
// - A lower-priority request waits until current handling ends.
// - A higher-priority request preempts and nests inside the current one.
// - Software trap may be set or cancelled during service, delivered later.
// - Trap set bit reads pending, clears on entry; writing zero does nothing.
// - Enable bit gates dispatch of each normal source; an asserted source pends while disabled and is sent once enabled.
// - Control status register shows read-only seven-bit vector of handled interrupt.
package irq_ctrl_pkg;
  localparam int NUM_SRC = 32;
  localparam int PRI_W = 10;
  localparam int DEPTH_W = 6;
  localparam logic [7:0] OFF_CTRL_STATUS = 8'h00;
  localparam logic [7:0] OFF_ENABLE = 8'h10;
  localparam logic [7:0] OFF_PEND_SET = 8'h18;
  localparam logic [7:0] OFF_PEND_CLEAR = 8'h1C;
  localparam logic [7:0] OFF_PRI_SEL_FIRST = 8'h40;
  localparam logic [7:0] OFF_PRI_SEL_LAST = 8'h5C;
  localparam logic [7:0] OFF_SYS_PRI_SEL = 8'h60;
  localparam logic [7:0] OFF_SRC_MODE = 8'h80;
  localparam int CS_SOFT_RESET_BIT = 31;
  localparam int CS_TRAP_SET_BIT = 26;
  localparam int CS_TRAP_CLEAR_BIT = 25;
  localparam int CS_VEC_LSB = 0;
  localparam int SYS_SPECIAL_FIELD_LSB = 14;
  localparam int SYS_SOFT_FIELD_LSB = 6;
  localparam int SEL_FIELD_LSB = 6;
  localparam logic [31:0] RESET_ENABLE = 32'h0000_0000;
  localparam logic [31:0] RESET_MODE = 32'h0000_0000;
  localparam logic [7:0] RESET_PRI_SEL = 8'h00;
  localparam logic [6:0] VEC_NONE = 7'h00;
  localparam logic [6:0] VEC_SPECIAL = 7'h02;
  localparam logic [6:0] VEC_SOFT = 7'h0E;
  localparam logic [6:0] VEC_FIRST_SRC = 7'h40;
  localparam logic signed [PRI_W-1:0] PRI_SPECIAL_BASE = -10'sd2;
  localparam logic signed [PRI_W-1:0] PRI_SOFT_BASE = -10'sd1;
  localparam logic signed [PRI_W-1:0] PRI_IDLE = 10'sh1FF;
  localparam logic signed [PRI_W-1:0] PRI_STEP = 10'sd64;
  localparam int IDX_SPECIAL = 32;
  localparam int IDX_SOFT = 33;
  localparam int NUM_ALL = 34;
endpackage

// >>> bench/core_model.sv
// Core model: takes each request after a chosen delay
module core_model
(
  input wire logic clk,
  input wire logic srst,
  input wire logic irq_req,
  input wire logic [3:0] ack_delay,
  output logic irq_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_q;
  // Ack lasts one cycle; the request drops right after it
  always_ff @(posedge clk)
  begin
    if (srst || !irq_req || irq_ack)
    begin
      wait_q <= 4'h0;
      irq_ack <= 1'b0;
    end
    else if (wait_q >= ack_delay)
      irq_ack <= 1'b1;
    else
      wait_q <= wait_q + 4'h1;
  end
endmodule // core_model

// >>> bench/irq_ctrl_checker_sva.sv
// Port checks for the interrupt controller
module irq_ctrl_checker
  import irq_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq_req,
  input wire logic [6:0] irq_vector,
  input wire logic irq_ack,
  input wire logic irq_return,
  input wire logic special_high_interrupt
);
  logic [2:0] depth_q;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // Nesting depth as seen from the core side
  always_ff @(posedge clk)
  begin
    if (srst)
      depth_q <= 3'h0;
    else if (irq_req && irq_ack)
      depth_q <= depth_q + 3'h1;
    else if (irq_return && depth_q != 3'h0)
      depth_q <= depth_q - 3'h1;
  end
  chk_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("pready too long");
  chk_err_unmapped: assert property (psel && !penable && paddr inside {[8'h20:8'h3C]} |=> pslverr)
    else $error("no error on hole");
  chk_sel_mapped: assert property (psel && !penable && paddr inside {[8'h40:8'h5C]}
    && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("error on select reg");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without pready");
  chk_ack_drops_req: assert property (irq_req && irq_ack |=> !irq_req)
    else $error("request kept after ack");
  chk_lone_special: assert property ($rose(special_high_interrupt) && depth_q == 3'h0 && !irq_req
    |-> ##[1:2] irq_req && irq_vector == VEC_SPECIAL)
    else $error("lone exception not sent");
  chk_reset_clear: assert property ($fell(srst) |-> !irq_req && irq_vector == VEC_NONE)
    else $error("outputs not cleared");
  cover property (irq_req && irq_ack && depth_q == 3'h1);
  cover property (irq_return && depth_q == 3'h2);
  cover property (pslverr);
endmodule // irq_ctrl_checker
bind prioritized_interrupt_controller irq_ctrl_checker u_chk (.clk, .srst, .psel, .penable,
  .paddr, .pready, .pslverr, .irq_req, .irq_vector, .irq_ack, .irq_return,
  .special_high_interrupt);

// >>> bench/testbench.sv
// Self-checking bench for the interrupt controller
module testbench;
  import irq_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdv, v;
  logic [3:0] pstrb = 4'hF, ack_delay = 4'h0;
  logic [NUM_SRC-1:0] irq_src = '0;
  logic special_high_interrupt = 1'b0, irq_return = 1'b0;
  logic pready, pslverr, irq_req, irq_ack, soft_reset_req, erv;
  logic [6:0] irq_vector;
  int num_errors = 0, checks_done = 0, seed, a, b, w, fa, fb;
  always #5 clk = ~clk;
  prioritized_interrupt_controller DUT (.clk, .srst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .irq_src, .special_high_interrupt,
    .irq_req, .irq_vector, .irq_ack, .irq_return, .soft_reset_req);
  core_model core (.clk, .srst, .irq_req, .ack_delay, .irq_ack);
  function automatic int pri(input int n, input int f);
    return n + 64 * f;
  endfunction
  task automatic finish_test();
    if (num_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr_en, input logic [7:0] ad, input logic [31:0] d,
    input logic [3:0] s);
    int n;
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= ad;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    if (n == 20)
    begin
      num_errors++;
      finish_test();
    end
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d, 4'hF);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] exp, input string what);
    apb(1'b0, ad, 32'h0, 4'hF);
    chk(rdv, exp, what);
  endtask
  // Byte lane write, so neighbouring selects must stay untouched
  task automatic sel(input int n, input int f);
    apb(1'b1, OFF_PRI_SEL_FIRST + 8'(n & 28), 32'(f) << (6 + 8 * (n % 4)), 4'h1 << (n % 4));
  endtask
  task automatic take(input int n);
    logic [31:0] got;
    got = 32'h0;
    ack_delay <= 4'($unsigned($random(seed)) % 4);
    repeat (40)
    begin
      @(posedge clk);
      if (irq_req === 1'b1 && irq_ack === 1'b1)
      begin
        got = {25'h0, irq_vector};
        break;
      end
    end
    chk(got, 32'(n), "vector");
  endtask
  // Extra edge first so a dropped level line is seen before the return
  task automatic ret();
    @(posedge clk);
    irq_return <= 1'b1;
    @(posedge clk);
    irq_return <= 1'b0;
    @(posedge clk);
  endtask
  task automatic quiet();
    logic s;
    s = 1'b0;
    repeat (8)
    begin
      @(posedge clk);
      s = s | irq_req;
    end
    chk({31'h0, s}, 32'h0, "idle request");
  endtask
  initial
  begin
    seed = 32'h3d4ce2b1;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(OFF_CTRL_STATUS, 32'h0, "status");
    wr(OFF_CTRL_STATUS, 32'h8000_0000);
    chk({31'h0, soft_reset_req}, 32'h1, "soft reset pulse");
    for (a = 0; a < 9; a++)
    begin
      rd(OFF_PRI_SEL_FIRST + 8'(4 * a), 32'h0, "select reset");
      v = $random(seed) & (a == 8 ? 32'h0000C0C0 : 32'hC0C0C0C0);
      wr(OFF_PRI_SEL_FIRST + 8'(4 * a), v);
      rd(OFF_PRI_SEL_FIRST + 8'(4 * a), v, "select");
      wr(OFF_PRI_SEL_FIRST + 8'(4 * a), 32'h0);
    end
    apb(1'b0, 8'h20, 32'h0, 4'hF);
    chk({31'h0, erv}, 32'h1, "hole error");
    wr(OFF_ENABLE, 32'hFFFFFFFF);
    wr(OFF_SRC_MODE, 32'h8);
    for (int k = 0; k < 8; k++)
    begin
      a = $unsigned($random(seed)) % 32;
      b = (a + 1 + $unsigned($random(seed)) % 31) % 32;
      fa = $unsigned($random(seed)) % 4;
      fb = $unsigned($random(seed)) % 4;
      sel(a, fa);
      sel(b, fb);
      w = pri(a, fa) < pri(b, fb) ? a : b;
      irq_src[a] <= 1'b1;
      irq_src[b] <= 1'b1;
      take(64 + w);
      irq_src[w] <= 1'b0;
      ret();
      take(64 + a + b - w);
      irq_src <= '0;
      ret();
      sel(a, 0);
      sel(b, 0);
    end
    irq_src[5] <= 1'b1;
    take(69);
    ret();
    take(69);
    special_high_interrupt <= 1'b1;
    take(VEC_SPECIAL);
    special_high_interrupt <= 1'b0;
    irq_src[9] <= 1'b1;
    irq_src[3] <= 1'b1;
    @(posedge clk);
    irq_src[3] <= 1'b0;
    quiet();
    wr(OFF_CTRL_STATUS, 32'h0400_0000);
    rd(OFF_CTRL_STATUS, 32'h0600_0000 | VEC_SPECIAL, "trap set");
    rd(OFF_PEND_CLEAR, 32'h208, "pending");
    wr(OFF_PEND_CLEAR, 32'h8);
    rd(OFF_PEND_CLEAR, 32'h200, "pending");
    ret();
    take(VEC_SOFT);
    rd(OFF_CTRL_STATUS, 32'(VEC_SOFT), "trap entered");
    ret();
    irq_src[5] <= 1'b0;
    ret();
    take(73);
    irq_src[9] <= 1'b0;
    ret();
    for (a = 0; a < 2; a++)
    begin
      irq_src[3] <= 1'b1;
      @(posedge clk);
      irq_src[3] <= 1'b0;
      if (a == 0)
        take(67);
      else
        ret();
    end
    take(67);
    ret();
    wr(OFF_ENABLE, 32'hFFFFFFEF);
    irq_src[4] <= 1'b1;
    quiet();
    wr(OFF_ENABLE, 32'hFFFFFFFF);
    take(68);
    irq_src[4] <= 1'b0;
    ret();
    special_high_interrupt <= 1'b1;
    take(VEC_SPECIAL);
    special_high_interrupt <= 1'b0;
    ret();
    finish_test();
  end
endmodule // testbench
